// File: rtl/cob_pkg.sv
// Package of object indexes, subindexes, reset values and types for the comm object bank
package cob_pkg;

    // ****************************************************************
    // Object dictionary addressing
    // ****************************************************************
    localparam logic [15:0] IDX_VERIFY    = 16'h1020;
    localparam logic [15:0] IDX_ERR_BEHAV = 16'h1029;
    localparam logic [15:0] IDX_RX1_COMM  = 16'h1400;
    localparam logic [15:0] IDX_RX2_COMM  = 16'h1401;
    localparam logic [15:0] IDX_RX3_COMM  = 16'h1402;
    localparam logic [15:0] IDX_RX1_MAP   = 16'h1600;
    localparam logic [15:0] IDX_RX2_MAP   = 16'h1601;
    localparam logic [15:0] IDX_RX3_MAP   = 16'h1602;
    localparam logic [7:0]  SUB_COUNT     = 8'h00;
    localparam logic [7:0]  SUB_FIRST     = 8'h01;
    localparam logic [7:0]  SUB_SECOND    = 8'h02;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [7:0]  RST_ENTRY_COUNT   = 8'h02;
    localparam logic [31:0] RST_DATE_STAMP    = 32'h00000000;
    localparam logic [31:0] RST_TIME_STAMP    = 32'h00000000;
    localparam logic [7:0]  RST_COMM_ERR_RESP = 8'h00;
    localparam logic [7:0]  RST_INT_ERR_RESP  = 8'h01;
    localparam logic [31:0] RST_RX_CAN_ID     = 32'h00000000;
    localparam logic [7:0]  RST_RX_VALIDITY   = 8'hFF;
    localparam int          RX_COUNT          = 3;

    // ****************************************************************
    // Error response codes
    // ****************************************************************
    localparam logic [7:0] RESP_PREOP = 8'h00;
    localparam logic [7:0] RESP_KEEP  = 8'h01;
    localparam logic [7:0] RESP_STOP  = 8'h02;

    // ****************************************************************
    // Network management states
    // ****************************************************************
    typedef enum logic [1:0] {
        COB_NMT_PREOP = 2'b00,
        COB_NMT_OPER  = 2'b01,
        COB_NMT_STOP  = 2'b10
    } cob_nmt_t;

    // ****************************************************************
    // Access request and answer
    // ****************************************************************
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [15:0] index;
        logic [7:0]  subindex;
        logic [31:0] wdata;
    } cob_req_t;

    typedef struct packed {
        logic        valid;
        logic        error;
        logic [31:0] rdata;
    } cob_rsp_t;

    // One receive channel's parameters
    typedef struct packed {
        logic [31:0] can_id;
        logic [7:0]  validity;
    } cob_rx_t;

endpackage

// File: rtl/cob_rx_param.sv
// One receive PDO parameter set with its own write decode
module cob_rx_param #(
    parameter logic [15:0] COMM_INDEX = 16'h1400,
    parameter logic [15:0] MAP_INDEX  = 16'h1600
) (
    input  wire logic              clock,
    input  wire logic              reset_n,
    input  wire cob_pkg::cob_req_t req,
    output cob_pkg::cob_rx_t       param,
    output logic [15:0]            map_index
);

    cob_pkg::cob_rx_t param_q;

    assign param     = param_q;
    assign map_index = MAP_INDEX;

    always_ff @(posedge clock)
    begin
        if (!reset_n)
            param_q.can_id <= cob_pkg::RST_RX_CAN_ID;
        else if (req.valid && req.write && req.index == COMM_INDEX
                 && req.subindex == cob_pkg::SUB_FIRST)
            param_q.can_id <= req.wdata;
    end

    always_ff @(posedge clock)
    begin
        if (!reset_n)
            param_q.validity <= cob_pkg::RST_RX_VALIDITY;
        else if (req.valid && req.write && req.index == COMM_INDEX
                 && req.subindex == cob_pkg::SUB_SECOND)
            param_q.validity <= req.wdata[7:0];
    end

endmodule

// File: rtl/cob_comm_bank.sv
// Communication object bank: verify stamps, error behaviour, receive PDO parameters
// Contract
// - Comm error: 00 preop, 01 keep
// - Other error: 00 preop, 01 keep, 02 stop
// - First subentry holds receive CAN identifier
// - Second subentry holds validity type, default FF
// - Sets one-three serve mappings 1600h-1602h
module cob_comm_bank (
    input  wire logic              clock,
    input  wire logic              reset_n,
    input  wire cob_pkg::cob_req_t req,
    output cob_pkg::cob_rsp_t      rsp,
    input  wire logic              nmt_start,
    input  wire logic              nmt_preop,
    input  wire logic              nmt_stop,
    input  wire logic              comm_error,
    input  wire logic              internal_error,
    output cob_pkg::cob_nmt_t      nmt_state,
    output logic [31:0]            date_stamp,
    output logic [31:0]            time_stamp,
    output cob_pkg::cob_rx_t       rx1_param,
    output cob_pkg::cob_rx_t       rx2_param,
    output cob_pkg::cob_rx_t       rx3_param
);

    // ****************************************************************
    // Storage
    // ****************************************************************
    logic [31:0]       date_q;
    logic [31:0]       time_q;
    logic [7:0]        comm_resp_q;
    logic [7:0]        int_resp_q;
    cob_pkg::cob_nmt_t state_q;
    cob_pkg::cob_nmt_t state_d;
    cob_pkg::cob_rsp_t rsp_q;
    cob_pkg::cob_rsp_t rsp_d;
    cob_pkg::cob_rx_t  rx_w [cob_pkg::RX_COUNT];
    logic [15:0]       map_w [cob_pkg::RX_COUNT];
    cob_pkg::cob_rx_t  rx_q [cob_pkg::RX_COUNT];
    logic              wr;

    assign wr = req.valid && req.write;

    // Sets bound to mappings 1600h to 1602h
    cob_rx_param #(
        .COMM_INDEX (cob_pkg::IDX_RX1_COMM),
        .MAP_INDEX  (cob_pkg::IDX_RX1_MAP)
    ) u_rx1 (
        .clock     (clock),
        .reset_n   (reset_n),
        .req       (req),
        .param     (rx_w[0]),
        .map_index (map_w[0])
    );

    cob_rx_param #(
        .COMM_INDEX (cob_pkg::IDX_RX2_COMM),
        .MAP_INDEX  (cob_pkg::IDX_RX2_MAP)
    ) u_rx2 (
        .clock     (clock),
        .reset_n   (reset_n),
        .req       (req),
        .param     (rx_w[1]),
        .map_index (map_w[1])
    );

    cob_rx_param #(
        .COMM_INDEX (cob_pkg::IDX_RX3_COMM),
        .MAP_INDEX  (cob_pkg::IDX_RX3_MAP)
    ) u_rx3 (
        .clock     (clock),
        .reset_n   (reset_n),
        .req       (req),
        .param     (rx_w[2]),
        .map_index (map_w[2])
    );

    // Registered copies so outputs come from flip-flops
    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            for (int i = 0; i < cob_pkg::RX_COUNT; i++)
            begin
                rx_q[i].can_id   <= cob_pkg::RST_RX_CAN_ID;
                rx_q[i].validity <= cob_pkg::RST_RX_VALIDITY;
            end
        end
        else
        begin
            for (int i = 0; i < cob_pkg::RX_COUNT; i++)
                rx_q[i] <= rx_w[i];
        end
    end

    assign rx1_param = rx_q[0];
    assign rx2_param = rx_q[1];
    assign rx3_param = rx_q[2];

    // ****************************************************************
    // Verify configuration stamps
    // ****************************************************************
    // Day count stored as written
    always_ff @(posedge clock)
    begin
        if (!reset_n)
            date_q <= cob_pkg::RST_DATE_STAMP;
        else if (wr && req.index == cob_pkg::IDX_VERIFY && req.subindex == cob_pkg::SUB_FIRST)
            date_q <= req.wdata;
    end

    always_ff @(posedge clock)
    begin
        if (!reset_n)
            time_q <= cob_pkg::RST_TIME_STAMP;
        else if (wr && req.index == cob_pkg::IDX_VERIFY && req.subindex == cob_pkg::SUB_SECOND)
            time_q <= req.wdata;
    end

    assign date_stamp = date_q;
    assign time_stamp = time_q;

    // ****************************************************************
    // Error behaviour selectors
    // ****************************************************************
    // Any 8-bit value stored, read back unchanged
    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            comm_resp_q <= cob_pkg::RST_COMM_ERR_RESP;
            int_resp_q  <= cob_pkg::RST_INT_ERR_RESP;
        end
        else if (wr && req.index == cob_pkg::IDX_ERR_BEHAV)
        begin
            if (req.subindex == cob_pkg::SUB_FIRST)
                comm_resp_q <= req.wdata[7:0];
            if (req.subindex == cob_pkg::SUB_SECOND)
                int_resp_q <= req.wdata[7:0];
        end
    end

    // ****************************************************************
    // Network management state
    // ****************************************************************
    // Errors outrank commands in the same cycle
    always_comb
    begin
        state_d = state_q;
        if (nmt_stop)
            state_d = cob_pkg::COB_NMT_STOP;
        else if (nmt_preop)
            state_d = cob_pkg::COB_NMT_PREOP;
        else if (nmt_start)
            state_d = cob_pkg::COB_NMT_OPER;
        if (comm_error && comm_resp_q == cob_pkg::RESP_PREOP
            && state_q == cob_pkg::COB_NMT_OPER)
            state_d = cob_pkg::COB_NMT_PREOP;
        if (internal_error)
        begin
            case (int_resp_q)
                cob_pkg::RESP_PREOP:
                begin
                    if (state_q == cob_pkg::COB_NMT_OPER)
                        state_d = cob_pkg::COB_NMT_PREOP;
                end
                cob_pkg::RESP_STOP:
                    state_d = cob_pkg::COB_NMT_STOP;
                default:
                    state_d = state_d;
            endcase
        end
    end

    always_ff @(posedge clock)
    begin
        if (!reset_n)
            state_q <= cob_pkg::COB_NMT_PREOP;
        else
            state_q <= state_d;
    end

    assign nmt_state = state_q;

    // ****************************************************************
    // Access answer
    // ****************************************************************
    always_comb
    begin
        rsp_d       = '0;
        rsp_d.valid = req.valid;
        case (req.index)
            cob_pkg::IDX_VERIFY:
            begin
                case (req.subindex)
                    cob_pkg::SUB_COUNT:  rsp_d.rdata = {24'h000000, cob_pkg::RST_ENTRY_COUNT};
                    cob_pkg::SUB_FIRST:  rsp_d.rdata = date_q;
                    cob_pkg::SUB_SECOND: rsp_d.rdata = time_q;
                    default:             rsp_d.error = 1'b1;
                endcase
                if (req.write && req.subindex == cob_pkg::SUB_COUNT)
                    rsp_d.error = 1'b1;
            end
            cob_pkg::IDX_ERR_BEHAV:
            begin
                case (req.subindex)
                    cob_pkg::SUB_COUNT:  rsp_d.rdata = {24'h000000, cob_pkg::RST_ENTRY_COUNT};
                    cob_pkg::SUB_FIRST:  rsp_d.rdata = {24'h000000, comm_resp_q};
                    cob_pkg::SUB_SECOND: rsp_d.rdata = {24'h000000, int_resp_q};
                    default:             rsp_d.error = 1'b1;
                endcase
                if (req.write && req.subindex == cob_pkg::SUB_COUNT)
                    rsp_d.error = 1'b1;
            end
            cob_pkg::IDX_RX1_COMM, cob_pkg::IDX_RX2_COMM, cob_pkg::IDX_RX3_COMM:
            begin
                case (req.subindex)
                    cob_pkg::SUB_COUNT:  rsp_d.rdata = {24'h000000, cob_pkg::RST_ENTRY_COUNT};
                    cob_pkg::SUB_FIRST:  rsp_d.rdata = rx_w[req.index[1:0]].can_id;
                    cob_pkg::SUB_SECOND: rsp_d.rdata = {24'h000000, rx_w[req.index[1:0]].validity};
                    default:             rsp_d.error = 1'b1;
                endcase
                if (req.write && req.subindex == cob_pkg::SUB_COUNT)
                    rsp_d.error = 1'b1;
            end
            map_w[0], map_w[1], map_w[2]:
            begin
                // Mapping objects live elsewhere; only refuse here
                rsp_d.error = 1'b1;
            end
            default:
                rsp_d.error = 1'b1;
        endcase
        if (!req.valid)
        begin
            rsp_d.error = 1'b0;
            rsp_d.rdata = 32'h00000000;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!reset_n)
            rsp_q <= '0;
        else
            rsp_q <= rsp_d;
    end

    assign rsp = rsp_q;

endmodule

// File: test/cob_cfg_master.sv
// Configuration master model issuing object dictionary accesses
module cob_cfg_master (
    input  wire logic              clock,
    output cob_pkg::cob_req_t      req,
    input  wire cob_pkg::cob_rsp_t rsp
);
    timeunit 1ns;
    timeprecision 100ps;
    initial req = '0;
    // Released request lines show the inverse, never the last value
    task automatic access(input logic wr, input logic [15:0] ix, input logic [7:0] sb,
                          input logic [31:0] wd, output cob_pkg::cob_rsp_t got);
        got = '0;
        @(posedge clock);
        #1 req = {1'b1, wr, ix, sb, wd};
        for (int n = 0; n < 4 && got.valid !== 1'b1; n++)
        begin
            @(posedge clock);
            #1 req = ~{1'b1, wr, ix, sb, wd};
            got = rsp;
        end
    endtask
    // days and milliseconds, both before storing
    task automatic stamp(input logic [31:0] days, input logic [31:0] ms);
        cob_pkg::cob_rsp_t got;
        access(1'b1, cob_pkg::IDX_VERIFY, cob_pkg::SUB_FIRST, days, got);
        access(1'b1, cob_pkg::IDX_VERIFY, cob_pkg::SUB_SECOND, ms, got);
    endtask
endmodule

// File: test/cob_comm_bank_assertions.sv
// Port checker of the comm object bank
module cob_comm_bank_chk (
    input wire logic              clock,
    input wire logic              reset_n,
    input wire cob_pkg::cob_req_t req,
    input wire cob_pkg::cob_rsp_t rsp,
    input wire logic              nmt_start,
    input wire logic              nmt_preop,
    input wire logic              nmt_stop,
    input wire logic              comm_error,
    input wire logic              internal_error,
    input wire cob_pkg::cob_nmt_t nmt_state,
    input wire cob_pkg::cob_rx_t  rx1_param,
    input wire cob_pkg::cob_rx_t  rx2_param
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] c_sel_q;
    logic [7:0] i_sel_q;
    logic       oper;
    logic       quiet;
    logic       eb_wr;
    assign oper = nmt_state == cob_pkg::COB_NMT_OPER;
    assign quiet = !(nmt_start || nmt_preop || nmt_stop);
    assign eb_wr = req.valid && req.write && req.index == cob_pkg::IDX_ERR_BEHAV;
    // Shadow of the two selectors
    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            c_sel_q <= cob_pkg::RST_COMM_ERR_RESP;
            i_sel_q <= cob_pkg::RST_INT_ERR_RESP;
        end
        else
        begin
            if (eb_wr && req.subindex == cob_pkg::SUB_FIRST)
                c_sel_q <= req.wdata[7:0];
            if (eb_wr && req.subindex == cob_pkg::SUB_SECOND)
                i_sel_q <= req.wdata[7:0];
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    a_comm_preop: assert property (
        comm_error && !internal_error && c_sel_q == 8'h00 && oper
        |=> nmt_state == cob_pkg::COB_NMT_PREOP) else $error("comm error kept operational");
    a_comm_keep: assert property (
        comm_error && !internal_error && c_sel_q == 8'h01 && quiet
        |=> $stable(nmt_state)) else $error("comm error changed state");
    a_int_preop: assert property (
        internal_error && !comm_error && i_sel_q == 8'h00 && oper
        |=> nmt_state == cob_pkg::COB_NMT_PREOP) else $error("error kept operational");
    a_int_stop: assert property (
        internal_error && !comm_error && i_sel_q == 8'h02
        |=> nmt_state == cob_pkg::COB_NMT_STOP) else $error("error did not stop");
    a_int_keep: assert property (
        internal_error && !comm_error && quiet && i_sel_q != 8'h00 && i_sel_q != 8'h02
        |=> $stable(nmt_state)) else $error("kept selector changed state");
    a_sel_readback: assert property (
        req.valid && !req.write && req.index == cob_pkg::IDX_ERR_BEHAV
        && req.subindex == cob_pkg::SUB_SECOND
        |=> rsp.valid && rsp.rdata == {24'h000000, i_sel_q}) else $error("selector readback");
    a_rx1_id_lag: assert property (
        req.valid && req.write && req.index == cob_pkg::IDX_RX1_COMM
        && req.subindex == cob_pkg::SUB_FIRST
        |-> ##2 rx1_param.can_id == $past(req.wdata, 2)) else $error("identifier not held");
    a_rx2_type_lag: assert property (
        req.valid && req.write && req.index == cob_pkg::IDX_RX2_COMM
        && req.subindex == cob_pkg::SUB_SECOND
        |-> ##2 rx2_param.validity == $past(req.wdata[7:0], 2)) else $error("type not held");
    a_map_refused: assert property (
        req.valid && req.index >= cob_pkg::IDX_RX1_MAP && req.index <= cob_pkg::IDX_RX3_MAP
        |=> rsp.valid && rsp.error) else $error("mapping access accepted");
    c_comm: cover property (comm_error && oper);
    c_stop: cover property (internal_error && i_sel_q == 8'h02);
    c_refuse: cover property (rsp.valid && rsp.error);
endmodule
bind cob_comm_bank cob_comm_bank_chk u_chk (
    .clock(clock), .reset_n(reset_n), .req(req), .rsp(rsp), .nmt_start(nmt_start),
    .nmt_preop(nmt_preop), .nmt_stop(nmt_stop), .comm_error(comm_error),
    .internal_error(internal_error), .nmt_state(nmt_state), .rx1_param(rx1_param),
    .rx2_param(rx2_param));

// File: test/cob_comm_bank_tb_top.sv
// Self-checking bench of the comm object bank
module cob_comm_bank_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic              clock;
    logic              reset_n;
    logic [4:0]        ctl;
    cob_pkg::cob_req_t req;
    cob_pkg::cob_rsp_t rsp;
    cob_pkg::cob_rsp_t got;
    cob_pkg::cob_nmt_t nmt_state;
    cob_pkg::cob_rx_t  rx_param [3];
    logic [31:0]       date_stamp;
    logic [31:0]       time_stamp;
    logic [15:0]       idx [5];
    logic [31:0]       ex2 [5];
    logic [7:0]        sel [7];
    logic [4:0]        ev [7];
    cob_pkg::cob_nmt_t ex [7];
    logic [7:0]        sb;
    int                errors;
    int                tests_run;
    cob_comm_bank u_dut (
        .clock(clock), .reset_n(reset_n), .req(req), .rsp(rsp), .nmt_start(ctl[4]),
        .nmt_preop(ctl[3]), .nmt_stop(ctl[2]), .comm_error(ctl[1]), .internal_error(ctl[0]),
        .nmt_state(nmt_state), .date_stamp(date_stamp), .time_stamp(time_stamp),
        .rx1_param(rx_param[0]), .rx2_param(rx_param[1]), .rx3_param(rx_param[2]));
    cob_cfg_master u_master (.clock(clock), .req(req), .rsp(rsp));
    initial
    begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("Checks %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic acc(input logic wr, input logic [15:0] ix, input logic [7:0] s,
                       input logic [31:0] wd);
        u_master.access(wr, ix, s, wd, got);
        check(got.valid, 1'b1);
        if (got.valid !== 1'b1)
            final_report();
    endtask
    task automatic pulse(input logic [4:0] v);
        @(posedge clock);
        #1 ctl = v;
        @(posedge clock);
        #1 ctl = '0;
    endtask
    initial
    begin
        ctl = '0;
        errors = 0;
        tests_run = 0;
        reset_n = 1'b0;
        idx = '{cob_pkg::IDX_VERIFY, cob_pkg::IDX_ERR_BEHAV, cob_pkg::IDX_RX1_COMM,
                cob_pkg::IDX_RX2_COMM, cob_pkg::IDX_RX3_COMM};
        ex2 = '{32'h00000000, 32'h00000001, 32'h000000FF, 32'h000000FF, 32'h000000FF};
        sel = '{8'h00, 8'h01, 8'h00, 8'h01, 8'h02, 8'h07, 8'h07};
        ev = '{5'h02, 5'h02, 5'h01, 5'h01, 5'h01, 5'h01, 5'h02};
        ex = '{cob_pkg::COB_NMT_PREOP, cob_pkg::COB_NMT_OPER, cob_pkg::COB_NMT_PREOP,
               cob_pkg::COB_NMT_OPER, cob_pkg::COB_NMT_STOP, cob_pkg::COB_NMT_OPER,
               cob_pkg::COB_NMT_OPER};
        repeat (3) @(posedge clock);
        #1 reset_n = 1'b1;
        for (int k = 0; k < 5; k++)
        begin
            acc(1'b0, idx[k], cob_pkg::SUB_COUNT, '0);
            check(got.rdata, 32'h00000002);
            acc(1'b0, idx[k], cob_pkg::SUB_FIRST, '0);
            check(got.rdata, 32'h00000000);
            acc(1'b0, idx[k], cob_pkg::SUB_SECOND, '0);
            check(got.rdata, ex2[k]);
            acc(1'b1, idx[k], cob_pkg::SUB_COUNT, 32'h00000055);
            check(got.error, 1'b1);
        end
        for (int k = 0; k < 3; k++)
        begin
            acc(1'b0, cob_pkg::IDX_RX1_MAP + 16'(k), cob_pkg::SUB_COUNT, '0);
            check(got.error, 1'b1);
            acc(1'b1, idx[k + 2], cob_pkg::SUB_FIRST, 32'h00000201 + 32'(k));
            acc(1'b1, idx[k + 2], cob_pkg::SUB_SECOND, 32'h00000001 + 32'(k));
            @(posedge clock);
            #1 check(rx_param[k].can_id, 32'h00000201 + 32'(k));
            check(rx_param[k].validity, 8'h01 + 8'(k));
        end
        // Noon on the first of January 1985
        u_master.stamp(32'h0000016E, 32'h02932E00);
        @(posedge clock);
        #1 check(date_stamp, 32'h0000016E);
        check(time_stamp, 32'h02932E00);
        for (int k = 0; k < 7; k++)
        begin
            sb = ev[k][1] ? cob_pkg::SUB_FIRST : cob_pkg::SUB_SECOND;
            acc(1'b1, cob_pkg::IDX_ERR_BEHAV, sb, 32'(sel[k]));
            pulse(5'h10);
            check(nmt_state, cob_pkg::COB_NMT_OPER);
            pulse(ev[k]);
            check(nmt_state, ex[k]);
            acc(1'b0, cob_pkg::IDX_ERR_BEHAV, sb, '0);
            check(got.rdata, 32'(sel[k]));
        end
        // Unknown object and unknown subentry are refused
        acc(1'b0, cob_pkg::IDX_RX3_COMM + 16'h0001, cob_pkg::SUB_FIRST, '0);
        check(got.error, 1'b1);
        acc(1'b0, cob_pkg::IDX_RX1_COMM, 8'h03, '0);
        check(got.error, 1'b1);
        // Plain commands, then a comm error outside operational
        pulse(5'h08);
        check(nmt_state, cob_pkg::COB_NMT_PREOP);
        pulse(5'h04);
        check(nmt_state, cob_pkg::COB_NMT_STOP);
        acc(1'b1, cob_pkg::IDX_ERR_BEHAV, cob_pkg::SUB_FIRST, 32'h00000000);
        pulse(5'h02);
        check(nmt_state, cob_pkg::COB_NMT_STOP);
        final_report();
    end
endmodule
